/* verilog/axreg_defines.svh */
// constants for the axis position registration latch
`ifndef AXREG_DEFINES_SVH
`define AXREG_DEFINES_SVH
`define AXREG_CLK_PERIOD_NS 10
`define AXREG_POS_W 32
`define AXREG_SRC_N 3
`define AXREG_REJ_CNT_W 8
`define AXREG_SERVO_PERIOD_NS 1000000
`define AXREG_CAPTURE_MAX_NS 500
`define AXREG_CAPTURE_LAT_CYC 4
`endif

/* verilog/axreg_pkg.sv */
// types shared by the registration latch files
`include "axreg_defines.svh"
package axreg_pkg;
  // capture source selected by the arming command
  typedef enum logic [1:0] {
    AXREG_SRC_IN_A,
    AXREG_SRC_IN_B,
    AXREG_SRC_ZMARK,
    AXREG_SRC_NONE
  } axreg_src_e;
  // position window mode
  typedef enum logic [1:0] {
    AXREG_WIN_OFF,
    AXREG_WIN_INCL,
    AXREG_WIN_EXCL,
    AXREG_WIN_RSVD
  } axreg_win_e;
  typedef logic signed [`AXREG_POS_W-1:0] axreg_pos_t;
  // capture_arm_command: one argument holds every option except the window positions
  typedef struct packed {
    axreg_src_e src;
    logic falling;
    axreg_win_e win;
  } axreg_cmd_s;
  typedef struct packed {
    axreg_pos_t window_open_position;
    axreg_pos_t window_close_position;
  } axreg_window_s;
  // delivered result: done flag and captured position
  typedef struct packed {
    logic mark;
    axreg_pos_t pos;
  } axreg_result_s;
endpackage

/* verilog/axreg_channel.sv */
// one independent latch circuit of the registration block
`timescale 1ns/1ps
`default_nettype none
`include "axreg_defines.svh"
module axreg_channel
  import axreg_pkg::*;
#(
  parameter int SERVO_PERIOD_CYC = 100000
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // timing and arming
  input wire logic servo_tick,
  input wire logic arm,
  input wire axreg_cmd_s cmd,
  input wire axreg_window_s win,
  // position and edge events
  input wire axreg_pos_t axis_position,
  input wire logic [`AXREG_SRC_N-1:0] src_rise,
  input wire logic [`AXREG_SRC_N-1:0] src_fall,
  // status
  output axreg_result_s result,
  output logic armed,
  output logic cap_evt,
  output logic reject_evt,
  output logic ignored_evt
);
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_HELD, ST_DONE} axreg_st_e;
  axreg_st_e state_q;
  axreg_cmd_s cmd_q;
  axreg_pos_t cap_q;
  logic hit;
  logic pass;
  logic deliver;
  logic [31:0] held_cnt_q;

  function automatic logic in_win(axreg_pos_t p, axreg_window_s w);
    in_win = (p >= w.window_open_position) &&
             (p <= w.window_close_position);
  endfunction

  // edge on the selected source, with the selected polarity
  always_comb
  begin
    hit = 1'b0;
    if (cmd_q.src != AXREG_SRC_NONE)
      hit = cmd_q.falling ? src_fall[cmd_q.src] : src_rise[cmd_q.src];
  end

  // window test on the live position at the edge
  always_comb
  begin
    case (cmd_q.win)
      AXREG_WIN_INCL: pass = in_win(axis_position, win);
      AXREG_WIN_EXCL: pass = !in_win(axis_position, win);
      default: pass = 1'b1;
    endcase
  end

  assign deliver = (state_q == ST_HELD) && servo_tick;
  assign cap_evt = (state_q == ST_ARMED) && hit && pass;
  assign reject_evt = (state_q == ST_ARMED) && hit && !pass;
  assign ignored_evt = ((state_q == ST_HELD) || (state_q == ST_DONE)) && hit;
  assign armed = (state_q == ST_ARMED);

  // latch sequence; a delivery in the arming cycle wins over the arm
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_IDLE;
    else if (arm && !deliver)
      state_q <= ST_ARMED;
    else
    begin
      case (state_q)
        ST_ARMED: if (cap_evt) state_q <= ST_HELD;
        ST_HELD: if (servo_tick) state_q <= ST_DONE;
        default: state_q <= state_q;
      endcase
    end
  end

  // command held for the whole armed period
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_q <= '{AXREG_SRC_NONE, 1'b0, AXREG_WIN_OFF};
    else if (arm && !deliver)
      cmd_q <= cmd;
  end

  // raw capture: the position itself, no interpolation needed
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cap_q <= '0;
    else if (cap_evt)
      cap_q <= axis_position;
  end

  // delivered result changes only at a servo tick or an arm
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      result <= '0;
    else if (deliver)
    begin
      result.mark <= 1'b1;
      result.pos <= cap_q;
    end
    else if (arm)
      result.mark <= 1'b0;
  end

  // helper: cycles spent waiting for delivery
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      held_cnt_q <= '0;
    else if (state_q == ST_HELD)
      held_cnt_q <= held_cnt_q + 32'h1;
    else
      held_cnt_q <= '0;
  end

  AST_ARM_CLEARS_MARK: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (arm && !deliver) |=> !result.mark
  ) else $error("arm did not clear the done flag");

  AST_DELIVER_VALUE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    deliver |=> result.mark && (result.pos == $past(cap_q))
  ) else $error("delivery did not present the captured value");

  AST_HOLD_FIRST: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state_q == ST_DONE && !arm) |=> $stable(result.pos) && result.mark
  ) else $error("result changed without a new arm");

  AST_INCL_WINDOW: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (cap_evt && cmd_q.win == AXREG_WIN_INCL) |->
      (axis_position >= win.window_open_position &&
       axis_position <= win.window_close_position)
  ) else $error("inclusive capture outside window");

  AST_EXCL_WINDOW: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (cap_evt && cmd_q.win == AXREG_WIN_EXCL) |->
      (axis_position < win.window_open_position ||
       axis_position > win.window_close_position)
  ) else $error("exclusive capture inside window");

  AST_REARM_ON_REJECT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (reject_evt && !arm) |=> armed && $stable(cap_q)
  ) else $error("rejected edge left the latch unarmed");

  AST_DELIVER_PERIOD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    held_cnt_q <= 32'(SERVO_PERIOD_CYC)
  ) else $error("capture not delivered within one servo period");

  AST_VALID_WITH_MARK: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $changed(result.pos) |-> $past(deliver)
  ) else $error("position changed outside a delivery");
endmodule
`default_nettype wire

/* verilog/axreg_top.sv */
// axis position registration latch: two channels on the encoder board
`timescale 1ns/1ps
`default_nettype none
`include "axreg_defines.svh"
module axreg_top
  import axreg_pkg::*;
#(
  parameter int SERVO_PERIOD_CYC =
    `AXREG_SERVO_PERIOD_NS / `AXREG_CLK_PERIOD_NS
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // registration pins and encoder zero mark, asynchronous
  input wire logic reg_in_a_pin,
  input wire logic reg_in_b_pin,
  input wire logic zero_mark_pin,
  // live position from the encoder counter on this clock
  input wire axreg_pos_t axis_position,
  // arming of latch a
  input wire logic arm_a,
  input wire axreg_cmd_s capture_arm_command_a,
  input wire axreg_window_s window_a,
  // arming of latch b
  input wire logic arm_b,
  input wire axreg_cmd_s capture_arm_command_b,
  input wire axreg_window_s window_b,
  // results
  output axreg_result_s result_a,
  output axreg_result_s result_b,
  // status
  output logic armed_a,
  output logic armed_b,
  output logic late_edge_a,
  output logic late_edge_b,
  output logic [`AXREG_REJ_CNT_W-1:0] reject_cnt_a,
  output logic [`AXREG_REJ_CNT_W-1:0] reject_cnt_b,
  output logic servo_tick
);
  localparam int CAPTURE_MAX_CYC =
    `AXREG_CAPTURE_MAX_NS / `AXREG_CLK_PERIOD_NS;
  localparam int CAPTURE_LAT_CYC = `AXREG_CAPTURE_LAT_CYC;

  logic rst_meta_q;
  logic rst_n;
  logic [`AXREG_SRC_N-1:0] pin_s1_q;
  logic [`AXREG_SRC_N-1:0] pin_s2_q;
  logic [`AXREG_SRC_N-1:0] pin_s3_q;
  logic [`AXREG_SRC_N-1:0] pin_raw;
  logic [`AXREG_SRC_N-1:0] rise_evt;
  logic [`AXREG_SRC_N-1:0] fall_evt;
  logic [31:0] tick_cnt_q;
  logic cap_a;
  logic cap_b;
  logic rej_a;
  logic rej_b;
  logic ign_a;
  logic ign_b;
  logic arm_st_a;
  logic arm_st_b;

  function automatic logic [`AXREG_REJ_CNT_W-1:0] sat_inc(
    logic [`AXREG_REJ_CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + `AXREG_REJ_CNT_W'(1);
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // raw pin vector; only the first synchroniser stage and checks read it
  assign pin_raw = {zero_mark_pin, reg_in_b_pin, reg_in_a_pin};

  // pin synchronisers; the third stage only serves edge detection
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // edges of all three sources, shared by both latches
  assign rise_evt = pin_s2_q & ~pin_s3_q;
  assign fall_evt = ~pin_s2_q & pin_s3_q;

  // servo update period divider, one-cycle enable pulse
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_q <= '0;
      servo_tick <= 1'b0;
    end
    else if (tick_cnt_q == 32'(SERVO_PERIOD_CYC - 1))
    begin
      tick_cnt_q <= '0;
      servo_tick <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      servo_tick <= 1'b0;
    end
  end

  // latch a; capture runs whatever the drive enable state is
  axreg_channel #(
    .SERVO_PERIOD_CYC(SERVO_PERIOD_CYC)
  ) u_latch_a (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .servo_tick(servo_tick),
    .arm(arm_a),
    .cmd(capture_arm_command_a),
    .win(window_a),
    .axis_position(axis_position),
    .src_rise(rise_evt),
    .src_fall(fall_evt),
    .result(result_a),
    .armed(arm_st_a),
    .cap_evt(cap_a),
    .reject_evt(rej_a),
    .ignored_evt(ign_a)
  );

  // latch b, fully independent of latch a
  axreg_channel #(
    .SERVO_PERIOD_CYC(SERVO_PERIOD_CYC)
  ) u_latch_b (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .servo_tick(servo_tick),
    .arm(arm_b),
    .cmd(capture_arm_command_b),
    .win(window_b),
    .axis_position(axis_position),
    .src_rise(rise_evt),
    .src_fall(fall_evt),
    .result(result_b),
    .armed(arm_st_b),
    .cap_evt(cap_b),
    .reject_evt(rej_b),
    .ignored_evt(ign_b)
  );

  // armed status, registered so the port comes from a flop
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_a <= 1'b0;
      armed_b <= 1'b0;
    end
    else
    begin
      armed_a <= arm_st_a;
      armed_b <= arm_st_b;
    end
  end

  // sticky edge-after-capture flags; a new edge wins over the arm clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      late_edge_a <= 1'b0;
      late_edge_b <= 1'b0;
    end
    else
    begin
      if (ign_a)
        late_edge_a <= 1'b1;
      else if (arm_a)
        late_edge_a <= 1'b0;
      if (ign_b)
        late_edge_b <= 1'b1;
      else if (arm_b)
        late_edge_b <= 1'b0;
    end
  end

  // window rejections, saturating; status only, never an interrupt
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reject_cnt_a <= '0;
      reject_cnt_b <= '0;
    end
    else
    begin
      if (rej_a)
        reject_cnt_a <= sat_inc(reject_cnt_a);
      else if (arm_a)
        reject_cnt_a <= '0;
      if (rej_b)
        reject_cnt_b <= sat_inc(reject_cnt_b);
      else if (arm_b)
        reject_cnt_b <= '0;
    end
  end

  // checks on the shared edge path, the divider and both latches
  AST_PIN_TO_EDGE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rise_evt[0] |-> $past(reg_in_a_pin, 2) && !$past(reg_in_a_pin, 3)
  ) else $error("registration edge not derived from the pin");

  AST_CAPTURE_NEEDS_EDGE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (cap_a || cap_b) |-> |(rise_evt | fall_evt)
  ) else $error("capture without any source edge");

  AST_CAPTURE_BUDGET: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (cap_a || cap_b) |-> (CAPTURE_LAT_CYC <= CAPTURE_MAX_CYC) &&
      |($past(pin_raw, CAPTURE_LAT_CYC - 2) ^
        $past(pin_raw, CAPTURE_LAT_CYC - 1))
  ) else $error("capture not within the allowed delay of a pin change");

  AST_TICK_SPACING: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    servo_tick |=> !servo_tick
  ) else $error("servo tick wider than one cycle");

  AST_TWO_LATCHES: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (arm_a && !arm_b && !result_b.mark && !servo_tick) |=>
      !result_b.mark
  ) else $error("arming latch a disturbed latch b");

  AST_REJECT_COUNT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rej_a && reject_cnt_a != '1) |=> reject_cnt_a == $past(reject_cnt_a) + 1
  ) else $error("window rejection not counted");

  AST_LATE_STICKY: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ign_a |=> late_edge_a
  ) else $error("edge after capture not flagged");

  AST_LATE_STICKY_B: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ign_b |=> late_edge_b
  ) else $error("edge after capture not flagged on latch b");

  AST_LATE_CLEAR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (arm_a && !ign_a) |=> !late_edge_a
  ) else $error("arm did not clear the late edge flag");

  AST_REJECT_CLEAR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (arm_a && !rej_a) |=> reject_cnt_a == '0
  ) else $error("arm did not clear the rejection count");

  AST_REJECT_COUNT_B: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rej_b && reject_cnt_b != '1) |=> reject_cnt_b == $past(reject_cnt_b) + 1
  ) else $error("window rejection not counted on latch b");

  AST_REJECT_SATURATE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rej_a && reject_cnt_a == '1) |=> reject_cnt_a == '1
  ) else $error("rejection count wrapped instead of holding");
endmodule
`default_nettype wire

/* testbench/axreg_enc_model.sv */
// incremental encoder model: live position count and zero mark
`timescale 1ns/1ps
`default_nettype none
module axreg_enc_model
  import axreg_pkg::*;
#(
  parameter int TURN_BITS = 6,
  parameter int MARK_LEN = 4
)
(
  // clock
  input wire logic core_clk,
  // motion enable from the bench
  input wire logic run,
  // encoder side
  output axreg_pos_t axis_position,
  output logic zero_mark_pin
);
  axreg_pos_t pos_q = '0;
  // position is read continuously, one count per cycle while moving
  always_ff @(posedge core_clk)
  begin
    if (run)
    begin
      pos_q <= pos_q + 1;
    end
  end
  assign axis_position = pos_q;
  // mark is wide enough for the pin synchroniser, once per turn
  assign zero_mark_pin =
    (pos_q[TURN_BITS-1:0] < TURN_BITS'(MARK_LEN));
endmodule
`default_nettype wire

/* testbench/axis_position_registration_latch_tb.sv */
// self-checking bench for the registration latch block
`timescale 1ns/1ps
`default_nettype none
`include "axreg_defines.svh"
`define CHK(got, exp, msg) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("CHECK FAILED at %0t: %s", $time, msg); \
    end \
  end
module axis_position_registration_latch_tb
  import axreg_pkg::*;
;
  localparam int SP = 16;
  localparam int LAT = `AXREG_CAPTURE_LAT_CYC;
  int fails = 0;
  int checked = 0;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  logic [1:0] pins = 2'h0;
  logic [1:0] arm_req = 2'h0;
  axreg_cmd_s cmd [2] = '{default: '0};
  axreg_window_s win [2] = '{default: '0};
  wire axreg_pos_t pos;
  wire logic zmark;
  wire axreg_result_s res [2];
  wire logic [1:0] armed;
  wire logic [1:0] late;
  wire logic [`AXREG_REJ_CNT_W-1:0] rej [2];
  wire logic tick;

  // clock generator
  always #(`AXREG_CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  axreg_enc_model enc_u (.core_clk(core_clk), .run(run),
    .axis_position(pos), .zero_mark_pin(zmark));

  axreg_top #(.SERVO_PERIOD_CYC(SP)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n),
    .reg_in_a_pin(pins[0]), .reg_in_b_pin(pins[1]),
    .zero_mark_pin(zmark), .axis_position(pos),
    .arm_a(arm_req[0]), .capture_arm_command_a(cmd[0]),
    .window_a(win[0]),
    .arm_b(arm_req[1]), .capture_arm_command_b(cmd[1]),
    .window_b(win[1]),
    .result_a(res[0]), .result_b(res[1]),
    .armed_a(armed[0]), .armed_b(armed[1]),
    .late_edge_a(late[0]), .late_edge_b(late[1]),
    .reject_cnt_a(rej[0]), .reject_cnt_b(rej[1]),
    .servo_tick(tick));

  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one arm pulse, then the cleared status two cycles on
  task automatic arm_latch(input int b, input axreg_cmd_s c,
    input axreg_pos_t op, input axreg_pos_t cl);
    @(posedge core_clk);
    arm_req[b] <= 1'b1;
    cmd[b] <= c;
    win[b] <= '{op, cl};
    @(posedge core_clk);
    arm_req[b] <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(res[b].mark, 1'b0, "done flag not cleared by arm")
    `CHK(armed[b], 1'b1, "latch not armed")
    `CHK(late[b], 1'b0, "late flag not cleared")
    `CHK(rej[b], 8'h00, "reject count not cleared")
  endtask

  // bounded wait for the done flag; running out ends the run
  task automatic wait_mark(input int b, input int bound);
    int n;
    n = 0;
    while (res[b].mark !== 1'b1 && n < bound)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= bound)
    begin
      fails++;
      $display("CHECK FAILED at %0t: no delivery in time", $time);
      final_report();
    end
  endtask

  // arm, make the selected edge, judge capture or rejection
  task automatic capture(input int b, input axreg_cmd_s c,
    input axreg_pos_t op, input axreg_pos_t cl, input logic pass);
    axreg_pos_t p0;
    axreg_result_s r;
    @(posedge core_clk);
    pins[c.src[0]] <= c.falling;
    arm_latch(b, c, op, cl);
    @(posedge core_clk);
    pins[c.src[0]] <= !c.falling;
    #1;
    p0 = pos;
    if (pass)
    begin
      wait_mark(b, SP + LAT + 2);
      r = res[b];
      `CHK(r.pos - p0 >= 0 && r.pos - p0 <= LAT, 1'b1, "bad position")
      // a second edge must leave the first capture alone
      @(posedge core_clk);
      pins[c.src[0]] <= c.falling;
      repeat (3) @(posedge core_clk);
      pins[c.src[0]] <= !c.falling;
      repeat (SP + LAT + 4) @(posedge core_clk);
      #1;
      `CHK(res[b], r, "held capture overwritten")
      `CHK(late[b], 1'b1, "late edge not flagged")
    end
    else
    begin
      repeat (SP + LAT + 4) @(posedge core_clk);
      #1;
      `CHK(res[b].mark, 1'b0, "edge outside window taken")
      `CHK(armed[b], 1'b1, "latch dropped on rejection")
      `CHK(rej[b], 8'h01, "rejection not counted")
    end
  endtask

  // status after reset
  task automatic s_reset();
    `CHK(res[0], 33'h0, "result a not idle")
    `CHK(res[1], 33'h0, "result b not idle")
    `CHK(armed, 2'h0, "armed after reset")
  endtask

  // each registration input, polarity and latch with a moving axis
  task automatic s_edges();
    axreg_cmd_s c;
    @(posedge core_clk);
    run <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      c.src = i[0] ? AXREG_SRC_IN_B : AXREG_SRC_IN_A;
      c.falling = i[1];
      c.win = AXREG_WIN_OFF;
      capture(i / 4, c, '0, '0, 1'b1);
    end
  endtask

  // window modes on a standing axis, boundaries included
  task automatic s_window();
    axreg_pos_t p;
    axreg_cmd_s c;
    @(posedge core_clk);
    run <= 1'b0;
    @(posedge core_clk);
    #1;
    p = pos;
    c = '{AXREG_SRC_IN_A, 1'b0, AXREG_WIN_INCL};
    capture(0, c, p + 1, p + 9, 1'b0);
    capture(0, c, p - 9, p - 1, 1'b0);
    capture(0, c, p, p, 1'b1);
    c.win = AXREG_WIN_EXCL;
    capture(1, c, p - 5, p + 5, 1'b0);
    capture(1, c, p + 1, p + 5, 1'b1);
    capture(1, c, p - 5, p - 1, 1'b1);
    c.win = AXREG_WIN_RSVD;
    capture(1, c, p + 1, p + 9, 1'b1);
  endtask

  // zero mark on one latch while the other captures an input
  task automatic s_zero_dual();
    @(posedge core_clk);
    pins[1] <= 1'b1;
    // axis stands while arming, so no zero mark edge races the arm checks
    arm_latch(0, '{AXREG_SRC_ZMARK, 1'b0, AXREG_WIN_OFF}, '0, '0);
    arm_latch(1, '{AXREG_SRC_IN_B, 1'b1, AXREG_WIN_OFF}, '0, '0);
    @(posedge core_clk);
    run <= 1'b1;
    pins[1] <= 1'b0;
    wait_mark(1, SP + LAT + 2);
    wait_mark(0, 64 + SP + LAT + 4);
    `CHK(res[0].pos[5:0] <= 6'(LAT + 1), 1'b1, "zero mark pos")
    `CHK(res[1].mark, 1'b1, "second latch lost")
  endtask

  // servo tick spacing, then an arm that selects no source
  task automatic s_misc();
    int n;
    @(posedge core_clk);
    run <= 1'b0;
    #1;
    n = 0;
    while (tick !== 1'b1 && n < 2 * SP)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (tick !== 1'b1 && n < 2 * SP);
    `CHK(n, SP, "servo tick period")
    arm_latch(0, '{AXREG_SRC_NONE, 1'b0, AXREG_WIN_OFF}, '0, '0);
    @(posedge core_clk);
    pins[0] <= ~pins[0];
    repeat (SP + LAT + 4) @(posedge core_clk);
    #1;
    `CHK(res[0].mark, 1'b0, "capture with no source selected")
    `CHK(armed[0], 1'b1, "latch left the armed state")
  endtask

  // hang guard
  initial
  begin
    #200000;
    fails++;
    final_report();
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    s_reset();
    s_edges();
    s_window();
    s_zero_dual();
    s_misc();
    final_report();
  end
endmodule
`default_nettype wire
